// *** hw/iowa_allocator.v ***
// Purpose: Automatic I/O word allocation with AXI4-Lite status registers
// Assumes: Units answer a req/ack scan handshake and hold their descriptor while ack is high
// Notes:   Scan runs once after reset; results hold until the next reset
//
// How it works
// RL1: Inputs handed out left to right from word 001, outputs from word 000.
// RL2: Word 000 always holds the sixteen processor inputs, before any unit.
// RL3: Every unit takes whole 16-bit words, an eight-point unit one full word.
// RL4: Upper bits of eight-point input words locked; of output words free as scratch.
// RL5: A sixteen-point unit gets one word, points 0 to 15 on bits 00 to 15.
// RL6: A thirty-two-point unit gets words n and n+1, connector A then B.
// RL7: Dedicated units get the input and output word counts they report.
// RL8: Inner boards and communications units are skipped, no words.
// RL9: Expansion control and interface units receive no words.
// RL10: Analog power supply gets no words but counts as a mounted unit.
// RL11: Expansion block units continue numbering without a gap.
// RL12: Input and output counters advance independently of mounting order.
// RL13: No empty slots; each unit gets the lowest free words.
// RL14: Exceeding capacity raises fatal overflow with the overflow error code.
// RL15: Large variant allows 15 input and 16 output words beyond word 000.
// RL16: Status bits 00 to 07 hold input word count in BCD, 01 to 16.
// RL17: Status bits 08 to 15 hold output word count in BCD, 00 to 16.
// RL18: Words left unassigned are reported free for program scratch use.
// RL19: No stored table; allocation derives from the units actually mounted.
// RL20: Scan runs once after reset before the program runs, results then fixed.
`timescale 1ns/1ps
`include "iowa_consts.vh"

module iowa_allocator (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        variant_large,
  output reg         scan_req,
  output reg  [4:0]  scan_sel,
  input  wire        scan_ack,
  input  wire [2:0]  unit_kind,
  input  wire [1:0]  unit_points,
  input  wire        unit_is_output,
  input  wire [2:0]  unit_in_words,
  input  wire [2:0]  unit_out_words,
  output reg         alloc_done,
  output reg         run_enable,
  output reg         fatal_overflow
);

  localparam [2:0] ST_SETTLE = 3'h0;
  localparam [2:0] ST_REQ    = 3'h1;
  localparam [2:0] ST_EVAL   = 3'h2;
  localparam [2:0] ST_REL    = 3'h3;
  localparam [2:0] ST_DONE   = 3'h4;
  localparam [2:0] ST_FAULT  = 3'h5;

  reg  [2:0]  state;
  reg  [3:0]  settle_cnt;
  reg         cap_large;
  reg  [5:0]  in_next;
  reg  [5:0]  out_next;
  reg  [4:0]  unit_count;
  reg  [15:0] in_used;
  reg  [15:0] out_used;
  reg  [15:0] in_lock;
  reg  [15:0] out_spare;
  reg  [4:0]  map_sel;
  reg  [21:0] unit_map [0:31];
  reg  [31:0] map_valid;

  // Three-stage synchronisers for pin inputs
  reg  [2:0]  ack_sync;
  reg         ack_q;
  reg  [2:0]  var_sync;
  reg         var_q;

  // Descriptor decode
  reg  [2:0]  need_in;
  reg  [2:0]  need_out;
  reg         counted;
  reg         chain_end;
  reg         eight_pt;
  wire [5:0]  in_end;
  wire [5:0]  out_end;
  wire [5:0]  small_total;
  wire        overflow;
  wire [15:0] in_hit;
  wire [15:0] out_hit;
  wire [15:0] counts_bcd;

  // AXI write side and read decode
  reg         aw_got;
  reg         w_got;
  reg  [7:0]  wr_addr;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_strb;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;

  function [7:0] to_bcd;
    input [5:0] v;
    reg   [5:0] low;
    begin
      low = v - 6'h0a;
      if (v >= 6'h0a)
        to_bcd = {4'h1, low[3:0]};
      else
        to_bcd = {4'h0, v[3:0]};
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      ack_sync <= 3'h0;
      ack_q    <= 1'b0;
      var_sync <= 3'h0;
      var_q    <= 1'b0;
    end else begin
      ack_sync <= {ack_sync[1:0], scan_ack};
      var_sync <= {var_sync[1:0], variant_large};
      if (ack_sync[1] == ack_sync[2])
        ack_q <= ack_sync[2];
      if (var_sync[1] == var_sync[2])
        var_q <= var_sync[2];
    end
  end

  // Word needs of the unit under scan, derived from what it reports [RL19]
  always @* begin
    need_in   = 3'h0;
    need_out  = 3'h0;
    counted   = 1'b0;
    chain_end = 1'b0;
    eight_pt  = 1'b0;
    case (unit_kind)
      `IOWA_KIND_END: begin
        chain_end = 1'b1;
      end
      `IOWA_KIND_IO: begin
        counted  = 1'b1;
        eight_pt = (unit_points == `IOWA_PTS_8); // [RL3]
        if (unit_is_output) begin
          if (unit_points == `IOWA_PTS_32)
            need_out = 3'h2; // [RL6]
          else
            need_out = 3'h1; // [RL3] [RL5]
        end else begin
          if (unit_points == `IOWA_PTS_32)
            need_in = 3'h2; // [RL6]
          else
            need_in = 3'h1; // [RL3] [RL5]
        end
      end
      `IOWA_KIND_DEDICATED: begin
        counted  = 1'b1;
        need_in  = unit_in_words; // [RL7]
        need_out = unit_out_words; // [RL7]
      end
      `IOWA_KIND_BOARD: begin
        counted = 1'b0; // [RL8]
      end
      `IOWA_KIND_EXPANSION: begin
        counted = 1'b0; // [RL9] [RL11]
      end
      `IOWA_KIND_APS: begin
        counted = 1'b1; // [RL10]
      end
      default: begin
        counted = 1'b0;
      end
    endcase
  end

  // Separate running counters for each direction [RL12] [RL13]
  assign in_end      = in_next + {3'h0, need_in};
  assign out_end     = out_next + {3'h0, need_out};
  assign small_total = in_end - `IOWA_IN_FIRST + out_end;

  // Capacity check by variant [RL14] [RL15]
  assign overflow = cap_large ? ((in_end > `IOWA_IN_LIMIT) || (out_end > `IOWA_OUT_LIMIT))
                              : (small_total > `IOWA_SMALL_LIMIT);

  // Words covered by the unit under scan
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_word
      localparam [5:0] WI = gi;
      assign in_hit[gi]  = (WI >= in_next) && (WI < in_end);
      assign out_hit[gi] = (WI >= out_next) && (WI < out_end);
    end
  endgenerate

  assign counts_bcd = {to_bcd(out_next), to_bcd(in_next)}; // [RL16] [RL17]

  always @(posedge aclk) begin
    if (!aresetn) begin
      state          <= ST_SETTLE;
      settle_cnt     <= 4'h0;
      cap_large      <= 1'b0;
      in_next        <= `IOWA_IN_FIRST; // [RL1] [RL2]
      out_next       <= `IOWA_OUT_FIRST; // [RL1]
      unit_count     <= 5'h00;
      in_used        <= `IOWA_RST_IN_USED; // [RL2]
      out_used       <= `IOWA_RST_ZERO16;
      in_lock        <= `IOWA_RST_ZERO16;
      out_spare      <= `IOWA_RST_ZERO16;
      map_valid      <= 32'h00000000;
      scan_req       <= 1'b0;
      scan_sel       <= 5'h00;
      alloc_done     <= 1'b0;
      run_enable     <= 1'b0;
      fatal_overflow <= 1'b0;
    end else begin
      case (state)
        ST_SETTLE: begin
          settle_cnt <= settle_cnt + 4'h1;
          if (settle_cnt == `IOWA_SETTLE_CYCLES - 4'h1) begin
            cap_large <= var_q;
            scan_req  <= 1'b1;
            state     <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (ack_q)
            state <= ST_EVAL;
        end
        ST_EVAL: begin
          scan_req <= 1'b0;
          if (chain_end) begin
            state <= ST_DONE;
          end else if (overflow) begin
            fatal_overflow <= 1'b1; // [RL14]
            alloc_done     <= 1'b1;
            state          <= ST_FAULT;
          end else begin
            in_next   <= in_end; // [RL1] [RL11] [RL13]
            out_next  <= out_end; // [RL1] [RL11] [RL13]
            in_used   <= in_used | in_hit;
            out_used  <= out_used | out_hit;
            in_lock   <= in_lock | (eight_pt ? in_hit : 16'h0000); // [RL4]
            out_spare <= out_spare | (eight_pt ? out_hit : 16'h0000); // [RL4]
            if (counted)
              unit_count <= unit_count + 5'h01; // [RL10]
            unit_map[scan_sel]  <= {in_next[4:0], need_in, out_next[4:0], need_out, 6'h00};
            map_valid[scan_sel] <= 1'b1;
            state               <= ST_REL;
          end
        end
        ST_REL: begin
          if (!ack_q) begin
            if (scan_sel == 5'h1f) begin
              state <= ST_DONE;
            end else begin
              scan_sel <= scan_sel + 5'h01;
              scan_req <= 1'b1;
              state    <= ST_REQ;
            end
          end
        end
        ST_DONE: begin
          alloc_done <= 1'b1;
          run_enable <= 1'b1; // [RL20]
        end
        ST_FAULT: begin
          alloc_done <= 1'b1;
          run_enable <= 1'b0;
        end
        default: begin
          state <= ST_FAULT;
        end
      endcase
    end
  end

  // Register read decode
  always @* begin
    next_rdata = 32'h00000000;
    next_rresp = `IOWA_RESP_OKAY;
    case (s_axi_araddr)
      `IOWA_OFS_COUNTS: begin
        next_rdata = {16'h0000, counts_bcd}; // [RL16] [RL17]
      end
      `IOWA_OFS_STATUS: begin
        next_rdata[`IOWA_ST_DONE] = alloc_done;
        next_rdata[`IOWA_ST_OVF]  = fatal_overflow;
        if (fatal_overflow)
          next_rdata[`IOWA_ST_CODE_LO +: 8] = `IOWA_OVF_CODE; // [RL14]
        next_rdata[`IOWA_ST_UNITS_LO +: 5] = unit_count;
      end
      `IOWA_OFS_IN_USED: begin
        next_rdata = {16'h0000, in_used}; // [RL18]
      end
      `IOWA_OFS_OUT_USED: begin
        next_rdata = {16'h0000, out_used}; // [RL18]
      end
      `IOWA_OFS_IN_LOCK: begin
        next_rdata = {16'h0000, in_lock}; // [RL4]
      end
      `IOWA_OFS_OUT_SPARE: begin
        next_rdata = {16'h0000, out_spare}; // [RL4]
      end
      `IOWA_OFS_MAP_SEL: begin
        next_rdata = {27'h0000000, map_sel};
      end
      `IOWA_OFS_MAP_DATA: begin
        if (map_valid[map_sel])
          next_rdata = {10'h000, unit_map[map_sel]};
      end
      default: begin
        next_rresp = `IOWA_RESP_SLVERR;
      end
    endcase
  end

  // AXI4-Lite read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `IOWA_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // AXI4-Lite write channels; address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IOWA_RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
      map_sel       <= 5'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got        <= 1'b1;
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got        <= 1'b1;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Only the map selector is writable; results stay fixed
        if (wr_addr == `IOWA_OFS_MAP_SEL) begin
          s_axi_bresp <= `IOWA_RESP_OKAY;
          if (wr_strb[0])
            map_sel <= wr_data[4:0];
        end else begin
          s_axi_bresp <= `IOWA_RESP_SLVERR; // [RL20]
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

endmodule

// *** hw/iowa_consts.vh ***
// Purpose: Shared constants of the I/O word allocator
// Assumes: Included by its bare name
// Notes:   Offsets are byte addresses on the register bus
`ifndef IOWA_CONSTS_VH
`define IOWA_CONSTS_VH

// Register byte offsets
`define IOWA_OFS_COUNTS       8'h00
`define IOWA_OFS_STATUS       8'h04
`define IOWA_OFS_IN_USED      8'h08
`define IOWA_OFS_OUT_USED     8'h0c
`define IOWA_OFS_IN_LOCK      8'h10
`define IOWA_OFS_OUT_SPARE    8'h14
`define IOWA_OFS_MAP_SEL      8'h18
`define IOWA_OFS_MAP_DATA     8'h1c

// Status field positions
`define IOWA_ST_DONE          0
`define IOWA_ST_OVF           1
`define IOWA_ST_CODE_LO       8
`define IOWA_ST_UNITS_LO      16

// Overflow error code value
`define IOWA_OVF_CODE         8'he1

// Unit kinds reported by a mounted unit
`define IOWA_KIND_END         3'h0
`define IOWA_KIND_IO          3'h1
`define IOWA_KIND_DEDICATED   3'h2
`define IOWA_KIND_BOARD       3'h3
`define IOWA_KIND_EXPANSION   3'h4
`define IOWA_KIND_APS         3'h5

// Point codes of a plain I/O unit
`define IOWA_PTS_8            2'h0
`define IOWA_PTS_16           2'h1
`define IOWA_PTS_32           2'h2

// Word numbering and capacity
`define IOWA_IN_FIRST         6'h01
`define IOWA_OUT_FIRST        6'h00
`define IOWA_IN_LIMIT         6'h10
`define IOWA_OUT_LIMIT        6'h10
`define IOWA_SMALL_LIMIT      6'h0f

// Reset values
`define IOWA_RST_IN_USED      16'h0001
`define IOWA_RST_ZERO16       16'h0000

// Cycles to let strap and handshake synchronisers settle after reset
`define IOWA_SETTLE_CYCLES    4'h8

// Bus responses
`define IOWA_RESP_OKAY        2'h0
`define IOWA_RESP_SLVERR      2'h2

`endif

// *** dv/iowa_allocator_properties.sv ***
// Purpose: Port-level properties of the I/O word allocator
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound onto every allocator instance
`timescale 1ns/1ps
module iowa_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        scan_req,
  input wire [4:0]  scan_sel,
  input wire        scan_ack,
  input wire        alloc_done,
  input wire        run_enable,
  input wire        fatal_overflow,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_settle_a: assert property ($rose(aresetn) |-> (!alloc_done && !scan_req && !fatal_overflow) [*6])
    else $error("scan or result seen too early after reset");
  scan_bound_a: assert property ($rose(aresetn) |-> ##[1:1000] alloc_done)
    else $error("scan did not finish in time");
  run_ok_a: assert property (run_enable |-> alloc_done && !fatal_overflow)
    else $error("run enabled without clean scan");
  ovf_halt_a: assert property (fatal_overflow |-> alloc_done && !run_enable)
    else $error("overflow without halt");
  results_held_a: assert property (alloc_done |=> alloc_done && !scan_req && $stable(run_enable) && $stable(fatal_overflow))
    else $error("results changed after scan");
  req_wait_a: assert property (scan_req && !scan_ack |=> scan_req && $stable(scan_sel))
    else $error("request dropped before answer");
  sel_step_a: assert property (!$stable(scan_sel) |-> scan_sel == $past(scan_sel) + 5'h1)
    else $error("unit index skipped");
  req_after_ack_a: assert property ($fell(scan_req) |-> $past(scan_ack) && $past(scan_ack, 2))
    else $error("request ended without answer");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule

bind iowa_allocator iowa_checker u_iowa_checker (
  .aclk(aclk), .aresetn(aresetn), .scan_req(scan_req), .scan_sel(scan_sel), .scan_ack(scan_ack),
  .alloc_done(alloc_done), .run_enable(run_enable), .fatal_overflow(fatal_overflow),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);

// *** dv/iowa_unit_chain.sv ***
// Purpose: Chain of mounted units answering the scan handshake
// Assumes: Bench fills tab before it pulses the allocator reset
// Notes:   Descriptor inverted once the unit lets go
`timescale 1ns/1ps
module iowa_unit_chain (
  input  wire        aclk,
  input  wire        scan_req,
  input  wire [4:0]  scan_sel,
  output reg         scan_ack,
  output reg  [11:0] desc
);
  reg     [11:0] tab [0:31];
  integer        dly;
  initial begin
    scan_ack = 1'b0;
    desc = 12'h000;
    dly = 1;
  end
  always @(posedge aclk) begin
    if (scan_req && !scan_ack) begin
      desc <= tab[scan_sel];
      dly <= dly - 1;
      if (dly <= 0) begin
        scan_ack <= 1'b1;
        dly <= 1 + $urandom % 4;
      end
    end else if (!scan_req && scan_ack) begin
      scan_ack <= 1'b0;
      desc <= ~desc;
    end
  end
endmodule

// *** dv/iowa_allocator_bench.sv ***
// Purpose: Self-checking bench of the I/O word allocator
// Assumes: Unit chain model stands on the scan side
// Notes:   Fixed corner chains, then seeded random chains
`timescale 1ns/1ps
`include "iowa_consts.vh"
module iowa_allocator_bench;
  reg          aclk = 1'b0;
  reg          aresetn = 1'b0;
  reg          vl = 1'b0;
  reg  [7:0]   aa = 8'h00;
  reg  [31:0]  wd = 32'h0;
  reg          awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  wire         awr, wrd, bv, arr, rv, req, ack, done, run, ovf;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [4:0]   sel;
  wire [11:0]  desc;
  integer      error_cnt = 0, total_checks = 0, i, k, c, n, t, e_un;
  reg  [31:0]  got;
  reg  [1:0]   rsp;
  reg          e_ov;
  reg  [15:0]  e_reg [0:5];
  reg  [31:0]  e_map [0:31];
  reg  [31:0]  e_msk [0:31];
  reg  [143:0] doc = 144'h280_600_2c0_200_340_410_800_300_a00_402_240_000;

  always #2.5 aclk = ~aclk;

  iowa_allocator u_iowa_allocator (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(aa), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .variant_large(vl), .scan_req(req), .scan_sel(sel), .scan_ack(ack),
    .unit_kind(desc[11:9]), .unit_points(desc[8:7]), .unit_is_output(desc[6]), .unit_in_words(desc[5:3]),
    .unit_out_words(desc[2:0]), .alloc_done(done), .run_enable(run), .fatal_overflow(ovf));

  iowa_unit_chain u_iowa_unit_chain (.aclk(aclk), .scan_req(req), .scan_sel(sel), .scan_ack(ack), .desc(desc));

  task conclude;
    begin
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task chk(input [39:0] g, input [39:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  task tmo(input integer lim);
    if (t >= lim) begin
      error_cnt = error_cnt + 1;
      conclude;
    end
  endtask

  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      aa <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      for (t = 0; t < 50 && !rv; t = t + 1) begin
        @(posedge aclk);
        if (arr) arv <= 1'b0;
      end
      tmo(50);
      got = rdata;
      rsp = rresp;
      rr <= 1'b0;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      aa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      for (t = 0; t < 50 && !bv; t = t + 1) begin
        @(posedge aclk);
        if (awr) awv <= 1'b0;
        if (wrd) wv <= 1'b0;
      end
      tmo(50);
      rsp = bresp;
      br <= 1'b0;
    end
  endtask

  function [7:0] bcd(input integer v);
    bcd = {4'(v / 10), 4'(v % 10)};
  endfunction

  function void predict;
    integer    j, ni, no, wi, wo;
    reg [11:0] d;
    reg        io, live;
    ni = 1;
    no = 0;
    live = 1'b1;
    e_ov = 1'b0;
    e_un = 0;
    e_reg[4] = 16'h0;
    e_reg[5] = 16'h0;
    for (j = 0; j < 31; j = j + 1) begin
      d = u_iowa_unit_chain.tab[j];
      io = d[11:9] == `IOWA_KIND_IO;
      wi = io && !d[6] ? 1 + (d[8:7] == `IOWA_PTS_32) : d[11:9] == `IOWA_KIND_DEDICATED ? d[5:3] : 0;
      wo = io && d[6] ? 1 + (d[8:7] == `IOWA_PTS_32) : d[11:9] == `IOWA_KIND_DEDICATED ? d[2:0] : 0;
      e_msk[j] = 32'h0;
      live = live && d[11:9] != `IOWA_KIND_END;
      if (live && (vl ? ni + wi > 16 || no + wo > 16 : ni + no + wi + wo > 16))
        e_ov = 1'b1;
      live = live && !e_ov;
      if (live) begin
        e_map[j] = {10'h0, 5'(ni), 3'(wi), 5'(no), 3'(wo), 6'h0};
        e_msk[j] = 32'hffffffff;
        e_un = e_un + (io || d[11:9] == `IOWA_KIND_DEDICATED || d[11:9] == `IOWA_KIND_APS);
        e_reg[4][ni] = e_reg[4][ni] | (io && d[8:7] == `IOWA_PTS_8 && !d[6]);
        e_reg[5][no] = e_reg[5][no] | (io && d[8:7] == `IOWA_PTS_8 && d[6]);
      end
      ni = live ? ni + wi : ni;
      no = live ? no + wo : no;
    end
    e_reg[0] = {bcd(no), bcd(ni)};
    e_reg[1] = e_ov ? {`IOWA_OVF_CODE, 8'h03} : 16'h0001;
    e_reg[2] = 16'((32'h1 << ni) - 1);
    e_reg[3] = 16'((32'h1 << no) - 1);
  endfunction

  task run_cfg;
    begin
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      predict();
      for (t = 0; t < 2000 && !done; t = t + 1)
        @(posedge aclk);
      tmo(2000);
      chk({run, ovf}, {!e_ov, e_ov});
      rd(8'h20);
      chk({rsp, got}, {`IOWA_RESP_SLVERR, 32'h0});
      wr(`IOWA_OFS_COUNTS, 32'hffff);
      chk(rsp, `IOWA_RESP_SLVERR);
      for (i = 0; i < 6; i = i + 1) begin
        rd(8'(i * 4));
        chk({rsp, got}, {`IOWA_RESP_OKAY, i == 1 ? {11'h0, 5'(e_un), e_reg[i]} : {16'h0, e_reg[i]}});
      end
      for (k = 0; k < 31; k = k + 1)
        if (e_msk[k] != 0) begin
          wr(`IOWA_OFS_MAP_SEL, k);
          chk(rsp, `IOWA_RESP_OKAY);
          rd(`IOWA_OFS_MAP_DATA);
          chk(got & e_msk[k], e_map[k] & e_msk[k]);
        end
    end
  endtask

  initial begin
    void'($urandom(32'h68ee));
    for (c = 0; c < 10; c = c + 1) begin
      n = 1 + $urandom % 20;
      vl <= c == 0 ? 1'b0 : c < 3 ? 1'b1 : c < 5 ? 1'b0 : 1'($urandom);
      for (k = 0; k < 32; k = k + 1)
        u_iowa_unit_chain.tab[k] = k < n ? {3'(1 + $urandom % 7), 3'($urandom), 3'($urandom % 5), 3'($urandom % 5)} : 12'h0;
      // Documented mix with skipped units, expansion and power supply
      for (k = 0; k < 32 && c == 0; k = k + 1)
        u_iowa_unit_chain.tab[k] = k < 12 ? doc[(11 - k) * 12 +: 12] : 12'h0;
      // Capacity edges, then one word more
      for (k = 0; k < 32 && c > 0 && c < 5; k = k + 1)
        u_iowa_unit_chain.tab[k] = k < 7 ? 12'h300 : k == 7 ? 12'h280 : k < 16 && c < 3 ? 12'h340 : 12'h0;
      if (c == 2) u_iowa_unit_chain.tab[16] = 12'h200;
      if (c == 4) u_iowa_unit_chain.tab[8] = 12'h240;
      run_cfg;
    end
    conclude;
  end
endmodule
